// *** rtl/vic_pkg.sv ***
// Shared constants for the 64-source interrupt controller and its core end
package vic_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NUM_SOURCES = 64;
   localparam int LEVEL_W     = 4;
   localparam int SRC_W       = 6;
   localparam int IDX_W       = 5;

   // ****************************************************************
   // Register indices (26 words)
   // ****************************************************************
   localparam logic [4:0] IDX_CONTROL     = 5'h00;
   localparam logic [4:0] IDX_MASK_LEVEL  = 5'h01;
   localparam logic [4:0] IDX_ENABLE_NUM  = 5'h02;
   localparam logic [4:0] IDX_DISABLE_NUM = 5'h03;
   localparam logic [4:0] IDX_ENABLE_UP   = 5'h04;
   localparam logic [4:0] IDX_ENABLE_LO   = 5'h05;
   localparam logic [4:0] IDX_TYPE_UP     = 5'h06;
   localparam logic [4:0] IDX_TYPE_LO     = 5'h07;
   localparam logic [4:0] IDX_PRIO_BASE   = 5'h08;   // 8 words, 0x08..0x0F
   localparam logic [4:0] IDX_NVEC_STATUS = 5'h10;
   localparam logic [4:0] IDX_FVEC_STATUS = 5'h11;
   localparam logic [4:0] IDX_RAW_UP      = 5'h12;
   localparam logic [4:0] IDX_RAW_LO      = 5'h13;
   localparam logic [4:0] IDX_FORCE_UP    = 5'h14;
   localparam logic [4:0] IDX_FORCE_LO    = 5'h15;
   localparam logic [4:0] IDX_NPEND_UP    = 5'h16;
   localparam logic [4:0] IDX_NPEND_LO    = 5'h17;
   localparam logic [4:0] IDX_FPEND_UP    = 5'h18;
   localparam logic [4:0] IDX_FPEND_LO    = 5'h19;

   // ****************************************************************
   // Fields and reset values
   // ****************************************************************
   localparam int CTRL_NORMAL_OFF_BIT = 0;
   localparam int CTRL_FAST_OFF_BIT   = 1;
   localparam int MASK_OFF_BIT        = 4;    // Set: no normal level masked
   localparam int NVEC_LEVEL_LSB      = 16;
   localparam logic [31:0] RST_CONTROL  = 32'h0000_0000;
   localparam logic [4:0]  RST_MASK     = 5'h1F;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic [31:0] NO_VECTOR    = 32'hFFFF_FFFF;

   // ****************************************************************
   // Core end: status bits, modes, vectors
   // ****************************************************************
   localparam int          STAT_I_BIT     = 7;
   localparam int          STAT_F_BIT     = 6;
   localparam logic [4:0]  MODE_NORMAL    = 5'b10010;
   localparam logic [4:0]  MODE_FAST      = 5'b10001;
   localparam logic [4:0]  MODE_SUPER     = 5'b10011;
   localparam logic [31:0] VEC_NORMAL     = 32'h0000_0018;
   localparam logic [31:0] VEC_FAST       = 32'h0000_001C;
   localparam logic [7:0]  RST_CORE_STAT  = 8'hD3;   // I and F set, supervisor

endpackage : vic_pkg

// *** rtl/vic_core_if.sv ***
// Request lines from the interrupt controller to the processor core
`timescale 1ns/1ps
interface vic_core_if;
   logic normal_req;
   logic fast_req;

   modport controller (output normal_req, output fast_req);
   modport core       (input  normal_req, input  fast_req);
endinterface : vic_core_if

// *** rtl/vic_controller.sv ***
// Vectored 64-source interrupt controller, device end
`timescale 1ns/1ps
module vic_controller
   import vic_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                       CORE_CLK_I,
   input  wire logic                       RST_N_I,
   input  wire logic                       CE_I,
   // Interrupt sources
   input  wire logic [vic_pkg::NUM_SOURCES-1:0] IRQ_SRC_I,
   // Register port
   input  wire logic                       REG_WR_I,
   input  wire logic                       REG_RD_I,
   input  wire logic [vic_pkg::IDX_W-1:0]  REG_IDX_I,
   input  wire logic [31:0]                REG_WDATA_I,
   output logic      [31:0]                REG_RDATA_O,
   // Requests to the core
   vic_core_if.controller                  CORE_IF
);
   import vic_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [31:0]          control;
   logic [4:0]           mask_level;
   logic [63:0]          enable;
   logic [63:0]          src_type;
   logic [63:0]          force_bits;
   logic [31:0]          prio [0:7];
   logic [63:0]          raw;
   logic [63:0]          npend;
   logic [63:0]          fpend;
   logic [31:0]          nvec;
   logic [31:0]          fvec;
   logic                 normal_req;
   logic                 fast_req;

   logic [63:0]          next_pend;
   logic [63:0]          next_npend;
   logic [63:0]          next_fpend;
   logic [31:0]          next_nvec;
   logic [31:0]          next_fvec;
   logic                 next_normal;
   logic [3:0]           best_level;
   logic                 best_found;
   logic [3:0]           lvl;
   logic                 wr_hit;

   // Level of one source out of the packed priority words
   function automatic logic [3:0] level_of(input int src, input logic [31:0] word);
      logic [4:0] lsb;
      lsb = 5'((src % 8) * LEVEL_W);
      level_of = word[lsb +: LEVEL_W];
   endfunction : level_of

   // Index of the highest set bit, or all ones when none is set
   function automatic logic [31:0] highest_set(input logic [63:0] vec);
      highest_set = NO_VECTOR;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         if (vec[i]) begin
            highest_set = 32'(i);
         end
      end
   endfunction : highest_set

   // Sources whose programmed level equals the given one
   function automatic logic [63:0] level_mask(input logic [3:0] want);
      level_mask = 64'h0;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         level_mask[i] = (level_of(i, prio[i / 8]) == want);
      end
   endfunction : level_mask

   assign wr_hit = CE_I && REG_WR_I;

   // ****************************************************************
   // Control, mask, type, force registers
   // ****************************************************************
   // Plain read/write storage
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         control    <= RST_CONTROL;
         mask_level <= RST_MASK;
         src_type   <= {2{RST_WORD}};
         force_bits <= {2{RST_WORD}};
      end else if (wr_hit) begin
         case (REG_IDX_I)
            IDX_CONTROL:    control             <= REG_WDATA_I;
            IDX_MASK_LEVEL: mask_level          <= REG_WDATA_I[4:0];
            IDX_TYPE_UP:    src_type[63:32]     <= REG_WDATA_I;
            IDX_TYPE_LO:    src_type[31:0]      <= REG_WDATA_I;
            IDX_FORCE_UP:   force_bits[63:32]   <= REG_WDATA_I;
            IDX_FORCE_LO:   force_bits[31:0]    <= REG_WDATA_I;
            default: ;
         endcase
      end
   end

   // Enable bits; by-number writes touch only the addressed bit
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         enable <= {2{RST_WORD}};
      end else if (wr_hit) begin
         case (REG_IDX_I)
            IDX_ENABLE_UP:   enable[63:32]                <= REG_WDATA_I;
            IDX_ENABLE_LO:   enable[31:0]                 <= REG_WDATA_I;
            IDX_ENABLE_NUM:  enable[REG_WDATA_I[SRC_W-1:0]] <= 1'b1;
            IDX_DISABLE_NUM: enable[REG_WDATA_I[SRC_W-1:0]] <= 1'b0;
            default: ;
         endcase
      end
   end

   // Priority words, four bits per source, eight sources per word
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         for (int k = 0; k < 8; k++) begin
            prio[k] <= RST_WORD;
         end
      end else if (wr_hit && (REG_IDX_I[4:3] == IDX_PRIO_BASE[4:3])) begin
         prio[REG_IDX_I[2:0]] <= REG_WDATA_I;
      end
   end

   // ****************************************************************
   // Arbitration
   // ****************************************************************
   // Fully recomputed each cycle; results land in flops so the core
   // and status reads see one consistent snapshot
   always_comb begin
      next_pend  = (IRQ_SRC_I | force_bits) & enable;
      next_fpend = next_pend & src_type;
      next_npend = next_pend & ~src_type;
      next_fvec  = highest_set(next_fpend);
      best_level = 4'h0;
      best_found = 1'b0;
      next_nvec  = NO_VECTOR;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         lvl = level_of(i, prio[i / 8]);
         // Only the top level is found here; ties resolve upward through highest_set below
         if (next_npend[i] && (!best_found || lvl >= best_level)) begin
            best_found = 1'b1;
            best_level = lvl;
         end
      end
      lvl = 4'h0;
      if (best_found) begin
         next_nvec = 32'h0;
         next_nvec[NVEC_LEVEL_LSB +: LEVEL_W] = best_level;
         next_nvec[SRC_W-1:0] = 6'(highest_set(next_npend & level_mask(best_level)));
      end
      // Threshold applies to the request line only, not the status view
      next_normal = best_found
                    && (mask_level[MASK_OFF_BIT] || best_level > mask_level[3:0]);
   end

   // Status snapshot and request lines
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         raw        <= {2{RST_WORD}};
         npend      <= {2{RST_WORD}};
         fpend      <= {2{RST_WORD}};
         nvec       <= NO_VECTOR;
         fvec       <= NO_VECTOR;
         normal_req <= 1'b0;
         fast_req   <= 1'b0;
      end else if (CE_I) begin
         raw        <= IRQ_SRC_I;
         npend      <= next_npend;
         fpend      <= next_fpend;
         nvec       <= next_nvec;
         fvec       <= next_fvec;
         normal_req <= next_normal && !control[CTRL_NORMAL_OFF_BIT];
         fast_req   <= (|next_fpend) && !control[CTRL_FAST_OFF_BIT];
      end
   end

   assign CORE_IF.normal_req = normal_req;
   assign CORE_IF.fast_req   = fast_req;

   // ****************************************************************
   // Register read
   // ****************************************************************
   // Data valid the cycle after the read strobe; unmapped reads zero
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         REG_RDATA_O <= RST_WORD;
      end else if (CE_I && REG_RD_I) begin
         case (REG_IDX_I)
            IDX_CONTROL:     REG_RDATA_O <= control;
            IDX_MASK_LEVEL:  REG_RDATA_O <= {27'h0, mask_level};
            IDX_ENABLE_UP:   REG_RDATA_O <= enable[63:32];
            IDX_ENABLE_LO:   REG_RDATA_O <= enable[31:0];
            IDX_TYPE_UP:     REG_RDATA_O <= src_type[63:32];
            IDX_TYPE_LO:     REG_RDATA_O <= src_type[31:0];
            IDX_NVEC_STATUS: REG_RDATA_O <= nvec;
            IDX_FVEC_STATUS: REG_RDATA_O <= fvec;
            IDX_RAW_UP:      REG_RDATA_O <= raw[63:32];
            IDX_RAW_LO:      REG_RDATA_O <= raw[31:0];
            IDX_FORCE_UP:    REG_RDATA_O <= force_bits[63:32];
            IDX_FORCE_LO:    REG_RDATA_O <= force_bits[31:0];
            IDX_NPEND_UP:    REG_RDATA_O <= npend[63:32];
            IDX_NPEND_LO:    REG_RDATA_O <= npend[31:0];
            IDX_FPEND_UP:    REG_RDATA_O <= fpend[63:32];
            IDX_FPEND_LO:    REG_RDATA_O <= fpend[31:0];
            default: begin
               if (REG_IDX_I[4:3] == IDX_PRIO_BASE[4:3]) begin
                  REG_RDATA_O <= prio[REG_IDX_I[2:0]];
               end else begin
                  REG_RDATA_O <= RST_WORD;   // By-number and unmapped
               end
            end
         endcase
      end
   end

endmodule : vic_controller

// *** rtl/vic_core_end.sv ***
// Processor-core end: takes normal and fast requests into exception entry
`timescale 1ns/1ps
module vic_core_end
   import vic_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   // Program flow
   input  wire logic [31:0] NEXT_PC_I,
   input  wire logic        SET_FLAGS_I,
   input  wire logic [1:0]  FLAGS_I,        // [1] normal disable, [0] fast disable
   input  wire logic        EXC_RETURN_I,
   // Exception entry results
   output logic             ENTRY_O,
   output logic [31:0]      VECTOR_O,
   output logic [31:0]      RETURN_ADDR_O,
   output logic [7:0]       STATUS_O,
   // Requests from the controller
   vic_core_if.core         CTRL_IF
);
   import vic_pkg::*;

   logic [7:0] saved_status;
   logic       take_fast;
   logic       take_normal;

   // ****************************************************************
   // Acceptance
   // ****************************************************************
   // Fast wins; a fast entry sets the normal disable too, so normal waits
   assign take_fast   = CTRL_IF.fast_req && !STATUS_O[STAT_F_BIT];
   assign take_normal = CTRL_IF.normal_req && !STATUS_O[STAT_I_BIT] && !take_fast;

   // Status, saved status, return address and vector
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         STATUS_O      <= RST_CORE_STAT;
         saved_status  <= RST_CORE_STAT;
         RETURN_ADDR_O <= RST_WORD;
         VECTOR_O      <= RST_WORD;
         ENTRY_O       <= 1'b0;
      end else if (CE_I) begin
         ENTRY_O <= take_fast || take_normal;
         if (take_fast) begin
            saved_status  <= STATUS_O;
            RETURN_ADDR_O <= NEXT_PC_I;
            STATUS_O      <= {2'b11, STATUS_O[5], MODE_FAST};
            VECTOR_O      <= VEC_FAST;
         end else if (take_normal) begin
            saved_status  <= STATUS_O;
            RETURN_ADDR_O <= NEXT_PC_I;
            STATUS_O      <= {1'b1, STATUS_O[6:5], MODE_NORMAL};
            VECTOR_O      <= VEC_NORMAL;
         end else if (EXC_RETURN_I) begin
            STATUS_O <= saved_status;
         end else if (SET_FLAGS_I) begin
            STATUS_O[STAT_I_BIT] <= FLAGS_I[1];
            STATUS_O[STAT_F_BIT] <= FLAGS_I[0];
         end
      end
   end

endmodule : vic_core_end

// *** testbench/vic_link_chk.sv ***
// Checker for the request link and the core end's exception entry
`timescale 1ns/1ps
module vic_link_chk
   import vic_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_N_I,
   // Link signals
   input  wire logic        normal_req,
   input  wire logic        fast_req,
   // Core end
   input  wire logic        SET_FLAGS_I,
   input  wire logic        EXC_RETURN_I,
   input  wire logic [31:0] NEXT_PC_I,
   input  wire logic        ENTRY_O,
   input  wire logic [31:0] VECTOR_O,
   input  wire logic [31:0] RETURN_ADDR_O,
   input  wire logic [7:0]  STATUS_O
);
   // ****************************************************************
   // Acceptance terms
   // ****************************************************************
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic take_f;
   logic take_n;
   logic quiet;
   // Flag writes on the same edge are left unjudged, though the core takes the entry ahead of them
   assign take_f = fast_req && !STATUS_O[STAT_F_BIT];
   assign take_n = normal_req && !STATUS_O[STAT_I_BIT] && !take_f;
   assign quiet  = !SET_FLAGS_I && !EXC_RETURN_I;

   a_fast_taken: assert property (take_f && quiet |=> ENTRY_O && VECTOR_O == VEC_FAST)
      else $error("fast request not taken");
   a_normal_taken: assert property (take_n && quiet |=> ENTRY_O && VECTOR_O == VEC_NORMAL)
      else $error("normal request not taken");
   a_blocked_idle: assert property (!take_f && !take_n |=> !ENTRY_O)
      else $error("entry while requests blocked");
   a_fast_entry_mode: assert property (ENTRY_O && VECTOR_O == VEC_FAST
      |-> STATUS_O[7:6] == 2'b11 && STATUS_O[4:0] == MODE_FAST)
      else $error("fast entry status wrong");
   a_normal_entry_mode: assert property (ENTRY_O && VECTOR_O == VEC_NORMAL
      |-> STATUS_O[STAT_I_BIT] && STATUS_O[4:0] == MODE_NORMAL)
      else $error("normal entry status wrong");
   a_entry_return_addr: assert property (ENTRY_O |-> RETURN_ADDR_O == $past(NEXT_PC_I))
      else $error("return address not saved");
   a_fast_no_reentry: assert property (ENTRY_O && VECTOR_O == VEC_FAST |=> !ENTRY_O)
      else $error("entry right after fast entry");
   a_entry_vector_legal: assert property (ENTRY_O
      |-> VECTOR_O == VEC_FAST || VECTOR_O == VEC_NORMAL)
      else $error("entry vector unknown");
endmodule : vic_link_chk

// *** testbench/vic_controller_tb.sv ***
// Self-checking bench for controller and core end joined by the link
`timescale 1ns/1ps
module vic_controller_tb;
   import vic_pkg::*;
   logic clk, rst_n, ce, reg_wr, reg_rd, setf, excr, entry, efr, enr;
   logic [4:0]  idx;
   logic [31:0] wd, rdata, npc, vec, ra, pw [8];
   logic [63:0] irq, src, en, ty, fr;
   logic [7:0]  stat;
   logic [4:0]  msk;
   logic [1:0]  flags, ctl;
   int mismatches, compares, n;
   vic_core_if link ();
   vic_controller u_vic_controller (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .IRQ_SRC_I(irq), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_IDX_I(idx),
      .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .CORE_IF(link));
   vic_core_end u_vic_core_end (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .NEXT_PC_I(npc), .SET_FLAGS_I(setf), .FLAGS_I(flags), .EXC_RETURN_I(excr),
      .ENTRY_O(entry), .VECTOR_O(vec), .RETURN_ADDR_O(ra), .STATUS_O(stat), .CTRL_IF(link));
   vic_link_chk u_vic_link_chk (.CORE_CLK_I(clk), .RST_N_I(rst_n),
      .normal_req(link.normal_req), .fast_req(link.fast_req), .SET_FLAGS_I(setf),
      .EXC_RETURN_I(excr), .NEXT_PC_I(npc), .ENTRY_O(entry), .VECTOR_O(vec),
      .RETURN_ADDR_O(ra), .STATUS_O(stat));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   always #50 clk = ~clk;
   task automatic results();
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(logic [4:0] i, logic [31:0] d);
      @(posedge clk) {reg_wr, idx, wd} <= {1'b1, i, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   // Read data lands on the edge that takes the strobe, one edge after it is driven
   task automatic rd(logic [4:0] i, logic [31:0] e, string nm);
      @(posedge clk) {reg_rd, idx} <= {1'b1, i};
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk(nm, rdata, e);
   endtask : rd
   task automatic rd2(logic [4:0] i, logic [63:0] e, string nm);
      rd(i, e[63:32], nm);
      rd(i + 5'h01, e[31:0], nm);
   endtask : rd2
   task automatic wr2(logic [4:0] i, logic [63:0] d);
      wr(i, d[63:32]);
      wr(i + 5'h01, d[31:0]);
   endtask : wr2
   function automatic int lvl(int s);
      return int'(pw[s/8][4*(s%8)+:4]);
   endfunction : lvl
   // Expected ranking worked out by plain scan, ascending so ties go high
   task automatic check_all();
      logic [63:0] p, np, fp;
      logic [31:0] nv, fv;
      int best;
      p = (src | fr) & en;
      np = p & ~ty;
      fp = p & ty;
      nv = NO_VECTOR;
      fv = NO_VECTOR;
      enr = 1'b0;
      best = -1;
      for (int s = 0; s < 64; s++) begin
         if (fp[s]) fv = 32'(s);
         if (np[s] && lvl(s) >= best) begin
            best = lvl(s);
            nv = (32'(best) << NVEC_LEVEL_LSB) | 32'(s);
         end
         if (np[s] && (msk[MASK_OFF_BIT] || lvl(s) > int'(msk[3:0]))) enr = 1'b1;
      end
      efr = (fp != 64'h0) && !ctl[1];
      enr = enr && !ctl[0];
      chk("fast_req", 32'(link.fast_req), 32'(efr));
      chk("normal_req", 32'(link.normal_req), 32'(enr));
      rd(IDX_NVEC_STATUS, nv, "nvec");
      rd(IDX_FVEC_STATUS, fv, "fvec");
      rd2(IDX_NPEND_UP, np, "npend");
      rd2(IDX_FPEND_UP, fp, "fpend");
      rd2(IDX_RAW_UP, src, "raw");
      rd2(IDX_FORCE_UP, fr, "force");
      rd2(IDX_TYPE_UP, ty, "type");
   endtask : check_all

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {clk, rst_n, reg_wr, reg_rd, setf, excr, idx, wd, irq, npc, flags} = '0;
      ce = 1'b1;
      {mismatches, compares} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      n = $urandom(32'h35A9);
      rd(IDX_MASK_LEVEL, 32'(RST_MASK), "mask");
      rd(IDX_FVEC_STATUS, NO_VECTOR, "fvec");
      rd(5'h1F, 32'h0, "unmapped");
      wr(IDX_FVEC_STATUS, 32'h0);
      rd(IDX_FVEC_STATUS, NO_VECTOR, "fvec ro");
      // Clock enable low: a write in that window must leave no trace
      @(posedge clk) ce <= 1'b0;
      wr(IDX_MASK_LEVEL, 32'h0);
      @(posedge clk) ce <= 1'b1;
      rd(IDX_MASK_LEVEL, 32'(RST_MASK), "mask frozen");
      // By-number writes touch one bit only
      for (int k = 0; k < 8; k++) begin
         en = {$urandom, $urandom};
         wr2(IDX_ENABLE_UP, en);
         n = (k == 0) ? 63 : $urandom_range(0, 63);
         wr(IDX_ENABLE_NUM, 32'(n));
         en[n] = 1'b1;
         rd2(IDX_ENABLE_UP, en, "enable num");
         n = (k == 1) ? 0 : $urandom_range(0, 63);
         wr(IDX_DISABLE_NUM, 32'(n));
         en[n] = 1'b0;
         rd2(IDX_ENABLE_UP, en, "disable num");
      end
      // Random mixes, first two pass ties and a full mask
      for (int k = 0; k < 40; k++) begin
         src = {$urandom, $urandom} & {$urandom, $urandom};
         fr = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
         en = {$urandom, $urandom};
         ty = (k % 3 == 0) ? 64'h0 : {$urandom, $urandom} & {$urandom, $urandom};
         msk = (k == 1) ? 5'h0F : 5'($urandom_range(0, 31));
         ctl = ($urandom_range(0, 3) == 0) ? 2'($urandom) : 2'b00;
         // Pin inputs change only at a rising edge
         @(posedge clk) npc <= $urandom;
         irq <= src;
         wr2(IDX_ENABLE_UP, en);
         wr2(IDX_TYPE_UP, ty);
         wr2(IDX_FORCE_UP, fr);
         for (int j = 0; j < 8; j++) begin
            pw[j] = (k == 0) ? 32'h7777_7777 : $urandom;
            wr(IDX_PRIO_BASE + 5'(j), pw[j]);
         end
         wr(IDX_MASK_LEVEL, 32'(msk));
         wr(IDX_CONTROL, 32'(ctl));
         repeat (3) @(posedge clk);
         #1 check_all();
         // Unmask the core and see which entry it takes
         @(posedge clk) {setf, flags} <= 3'b100;
         @(posedge clk) setf <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         if (efr) chk("fast mode", {stat[7:6], stat[4:0]}, {2'b11, MODE_FAST});
         else if (enr) chk("normal mode", {stat[7:6], stat[4:0]}, {2'b10, MODE_NORMAL});
         if (efr || enr) chk("return addr", ra, npc);
         // Block both lines first, or the unmasked return would re-enter at once
         wr(IDX_CONTROL, 32'h3);
         @(posedge clk) excr <= 1'b1;
         @(posedge clk) {excr, setf, flags} <= 4'b0111;
         @(posedge clk) setf <= 1'b0;
      end
      results();
   end
   // Watchdog well past the expected run length
   initial begin
      #2000000;
      mismatches++;
      results();
   end
endmodule : vic_controller_tb
